// file: shared/lepm_defines.svh
// Register offsets, field positions, reset values and timing counts of the link event and probe manager
`ifndef LEPM_DEFINES_SVH
`define LEPM_DEFINES_SVH
// Register byte offsets, compared against haddr[11:0]
`define LEPM_MON_ADDR_LO 12'h000
`define LEPM_MON_ADDR_HI 12'h004
`define LEPM_MON_CMD 12'h008
`define LEPM_MON_STAT 12'h00c
`define LEPM_PRB_ADDR_LO 12'h010
`define LEPM_PRB_ADDR_HI 12'h014
`define LEPM_PRB_CTRL 12'h018
`define LEPM_PRB_TIMEOUT 12'h01c
`define LEPM_PRB_STAT 12'h020
`define LEPM_IRQ_STAT 12'h024
`define LEPM_IRQ_MASK 12'h028
// Field positions
`define LEPM_CMD_EN_BIT 0
`define LEPM_CMD_GO_BIT 1
`define LEPM_PRB_EXP_BIT 8
`define LEPM_PRB_GO_BIT 9
`define LEPM_PRB_SPEC_LSB 16
`define LEPM_IRQ_MON 0
`define LEPM_IRQ_EVT 1
`define LEPM_IRQ_PRB 2
// Reset values
`define LEPM_IRQ_RST 3'h0
`define LEPM_TMO_RST 16'h0000
// Frame check sequence length excluded from the payload size
`define LEPM_FCS_BYTES 14'h0004
// Timing: one millisecond at the 10 ns clock
`define LEPM_MS_NS 1000000
`define LEPM_CLK_NS 10
`define LEPM_MS_CYCLES ((`LEPM_MS_NS + `LEPM_CLK_NS - 1) / `LEPM_CLK_NS)
`endif

// file: shared/lepm_pkg.sv
// Types shared by the link event and probe manager
package lepm_pkg;
  // Link event classes
  typedef enum logic [1:0] {EVT_RX_OK, EVT_RX_ERR, EVT_TX_OK, EVT_TX_ERR} lepm_evt_t;
  // Eight encoded PHY rates, lowest to highest
  typedef enum logic [2:0] {RATE_53_3, RATE_80, RATE_106_7, RATE_160, RATE_200, RATE_320, RATE_400,
                            RATE_480} lepm_rate_t;
  // Receive error detail
  typedef enum logic [1:0] {RXE_NONE, RXE_PAYLOAD, RXE_UNSUP_RATE, RXE_GENERAL} lepm_rxerr_t;
  // Probe engine states
  typedef enum logic [1:0] {PRB_IDLE, PRB_SEND, PRB_WAIT_BCN, PRB_WAIT_RESP} lepm_prb_state_t;
endpackage : lepm_pkg

// file: core/lepm_ms_timer.sv
// Millisecond timeout timer for a pending probe request
`include "lepm_defines.svh"
module lepm_ms_timer import lepm_pkg::*; #(
  parameter int MS_CYCLES = `LEPM_MS_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [15:0] ms_i,
  output logic expired_o
);
  localparam logic [16:0] CYC_LAST = 17'(MS_CYCLES - 1);

  logic run;
  logic [16:0] cyc;
  logic [15:0] ms_left;
  logic next_run;
  logic [16:0] next_cyc;
  logic [15:0] next_ms_left;
  logic next_expired;

  // A zero timeout expires two cycles after the start
  always_comb begin
    next_run = run;
    next_cyc = cyc;
    next_ms_left = ms_left;
    next_expired = 1'b0;
    if (start_i) begin
      next_run = 1'b1;
      next_cyc = 17'h00000;
      next_ms_left = ms_i;
    end else if (stop_i) begin
      next_run = 1'b0;
    end else if (run) begin
      if (ms_left == 16'h0000) begin
        next_run = 1'b0;
        next_expired = 1'b1;
      end else if (cyc == CYC_LAST) begin
        next_cyc = 17'h00000;
        next_ms_left = ms_left - 16'h0001;
      end else begin
        next_cyc = cyc + 17'h00001;
      end
    end
  end

  // Timer registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run <= 1'b0;
      cyc <= 17'h00000;
      ms_left <= 16'h0000;
      expired_o <= 1'b0;
    end else begin
      run <= next_run;
      cyc <= next_cyc;
      ms_left <= next_ms_left;
      expired_o <= next_expired;
    end
  end
endmodule : lepm_ms_timer

// file: core/lepm_top.sv
// Link event monitor, monitor table and probe request engine with an AHB-Lite register slave
`include "lepm_defines.svh"
// How it works
// - Report events only for monitored remote addresses
// - Table empty at reset; enable adds address
// - Flag beacons; access method zero for beacons
// - Classify rx/tx success/error by ack policy
// - Payload size excludes frame check sequence
// - Error detail only on receive errors
// - Retry count equals transmission attempts
// - Attach delivery id in reservations; report rate
// - Rate is one of eight codes
// - Confirm once state applied, or failure
// - Explicit via command frame, implicit via beacon
// - Implicit request rides the next beacon
// - Command frame uses immediate acknowledgement
// - Millisecond timeout ends request with timeout
// - Probe only targets probe-capable devices
module lepm_top import lepm_pkg::*; #(
  parameter int MS_CYCLES = `LEPM_MS_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic ev_valid_i,
  input wire logic [47:0] ev_addr_i,
  input wire logic ev_beacon_i,
  input wire logic ev_tx_i,
  input wire logic ev_ok_i,
  input wire logic ev_ack_policy_i,
  input wire logic ev_drp_i,
  input wire logic [13:0] ev_len_i,
  input wire lepm_rate_t ev_rate_i,
  input wire logic [3:0] ev_attempts_i,
  input wire lepm_rxerr_t ev_rxerr_i,
  input wire logic [3:0] ev_delivery_id_i,
  output logic evt_valid_o,
  output lepm_evt_t evt_type_o,
  output logic evt_beacon_o,
  output logic evt_drp_o,
  output logic [13:0] evt_payload_o,
  output lepm_rate_t evt_rate_o,
  output logic [47:0] evt_addr_o,
  output logic [3:0] evt_retry_o,
  output lepm_rxerr_t evt_rxerr_o,
  output logic [3:0] evt_delivery_id_o,
  input wire logic prb_target_cap_i,
  output logic prb_cmd_valid_o,
  input wire logic prb_cmd_ready_i,
  output logic prb_cmd_imm_ack_o,
  output logic prb_bcn_req_o,
  input wire logic bcn_tx_i,
  output logic [47:0] prb_dest_o,
  output logic [7:0] prb_ie_id_o,
  output logic [15:0] prb_spec_o,
  input wire logic prb_resp_valid_i,
  input wire logic [47:0] prb_resp_addr_i,
  output logic irq_o
);
  localparam int MON_N = 4;

  // Exact match of a valid table entry
  function automatic logic lepm_match(input logic vld, input logic [47:0] a, input logic [47:0] b);
    return vld && (a == b);
  endfunction : lepm_match

  // Bus address phase capture
  logic ap_wr;
  logic [11:0] ap_addr;
  logic next_ap_wr, next_ap_rd;
  logic [11:0] next_ap_addr;
  logic [31:0] next_hrdata;
  // Software registers
  logic [47:0] mon_addr, prb_addr;
  logic mon_en_req, mon_busy, mon_ok;
  logic [15:0] prb_tmo;
  logic [2:0] irq_stat, irq_mask;
  logic [47:0] next_mon_addr, next_prb_addr;
  logic next_mon_en_req, next_mon_busy, next_mon_ok;
  logic [15:0] next_prb_tmo;
  logic [2:0] next_irq_stat, next_irq_mask, irq_set;
  // Monitor table
  logic [MON_N-1:0] mon_vld, next_mon_vld, req_hit, ev_hit_v;
  logic [47:0] mon_tab [MON_N];
  logic [47:0] next_mon_tab [MON_N];
  logic ev_hit, wr_go_mon, wr_go_prb;
  // Probe engine
  lepm_prb_state_t prb_st, next_prb_st;
  logic prb_ok, prb_refused, prb_exp;
  logic [7:0] next_ie_id;
  logic [15:0] next_spec;
  logic [47:0] next_dest;
  logic next_prb_ok, next_prb_refused, next_cmd_valid, next_bcn_req;
  logic tmr_start, tmr_stop, tmr_expired;

  // Per-entry address compare for both the request and the event path
  generate
    for (genvar g = 0; g < MON_N; g++) begin : g_cmp
      assign req_hit[g] = lepm_match(mon_vld[g], mon_tab[g], mon_addr);
      assign ev_hit_v[g] = lepm_match(mon_vld[g], mon_tab[g], ev_addr_i);
    end
  endgenerate
  assign ev_hit = |ev_hit_v;

  assign wr_go_mon = ap_wr && (ap_addr == `LEPM_MON_CMD) && hwdata_i[`LEPM_CMD_GO_BIT];
  assign wr_go_prb = ap_wr && (ap_addr == `LEPM_PRB_CTRL) && hwdata_i[`LEPM_PRB_GO_BIT];

  // Bus slave: zero wait states, always OKAY, unmapped reads give zero
  always_comb begin
    next_ap_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    next_ap_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    next_ap_addr = haddr_i[11:0];
    next_hrdata = 32'h00000000;
    if (next_ap_rd) begin
      case (haddr_i[11:0])
        `LEPM_MON_ADDR_LO: next_hrdata = mon_addr[31:0];
        `LEPM_MON_ADDR_HI: next_hrdata = {16'h0000, mon_addr[47:32]};
        `LEPM_MON_STAT: next_hrdata = {24'h000000, mon_vld, 2'b00, mon_ok, mon_busy};
        `LEPM_PRB_ADDR_LO: next_hrdata = prb_addr[31:0];
        `LEPM_PRB_ADDR_HI: next_hrdata = {16'h0000, prb_addr[47:32]};
        `LEPM_PRB_CTRL: next_hrdata = {prb_spec_o, 8'h00, prb_ie_id_o};
        `LEPM_PRB_TIMEOUT: next_hrdata = {16'h0000, prb_tmo};
        `LEPM_PRB_STAT: next_hrdata = {29'h00000000, prb_refused, prb_ok, prb_st != PRB_IDLE};
        `LEPM_IRQ_STAT: next_hrdata = {29'h00000000, irq_stat};
        `LEPM_IRQ_MASK: next_hrdata = {29'h00000000, irq_mask};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Software registers, monitor request and interrupt status
  always_comb begin
    next_mon_addr = mon_addr;
    next_prb_addr = prb_addr;
    next_mon_en_req = mon_en_req;
    next_mon_busy = mon_busy;
    next_mon_ok = mon_ok;
    next_prb_tmo = prb_tmo;
    next_irq_mask = irq_mask;
    next_mon_vld = mon_vld;
    next_mon_tab = mon_tab;
    irq_set = 3'h0;
    if (ap_wr) begin
      case (ap_addr)
        `LEPM_MON_ADDR_LO: if (!mon_busy) next_mon_addr[31:0] = hwdata_i;
        `LEPM_MON_ADDR_HI: if (!mon_busy) next_mon_addr[47:32] = hwdata_i[15:0];
        `LEPM_PRB_ADDR_LO: if (prb_st == PRB_IDLE) next_prb_addr[31:0] = hwdata_i;
        `LEPM_PRB_ADDR_HI: if (prb_st == PRB_IDLE) next_prb_addr[47:32] = hwdata_i[15:0];
        `LEPM_PRB_TIMEOUT: if (prb_st == PRB_IDLE) next_prb_tmo = hwdata_i[15:0];
        `LEPM_IRQ_MASK: next_irq_mask = hwdata_i[2:0];
        default: ;
      endcase
    end
    // A go while busy is dropped so only one change is ever outstanding
    if (wr_go_mon && !mon_busy) begin
      next_mon_busy = 1'b1;
      next_mon_en_req = hwdata_i[`LEPM_CMD_EN_BIT];
    end
    // Apply the change, then confirm; a full table fails at once rather than waiting
    if (mon_busy) begin
      next_mon_busy = 1'b0;
      irq_set[`LEPM_IRQ_MON] = 1'b1;
      next_mon_ok = 1'b1;
      if (!mon_en_req) begin
        next_mon_vld = mon_vld & ~req_hit;
      end else if (req_hit == '0) begin
        next_mon_ok = 1'b0;
        for (int i = MON_N - 1; i >= 0; i--) begin
          if (!mon_vld[i]) begin
            next_mon_ok = 1'b1;
          end
        end
        if (mon_vld[0] == 1'b0) begin
          next_mon_vld[0] = 1'b1;
          next_mon_tab[0] = mon_addr;
        end else if (mon_vld[1] == 1'b0) begin
          next_mon_vld[1] = 1'b1;
          next_mon_tab[1] = mon_addr;
        end else if (mon_vld[2] == 1'b0) begin
          next_mon_vld[2] = 1'b1;
          next_mon_tab[2] = mon_addr;
        end else if (mon_vld[3] == 1'b0) begin
          next_mon_vld[3] = 1'b1;
          next_mon_tab[3] = mon_addr;
        end
      end
    end
    if (ev_valid_i && ev_hit && !(ev_beacon_i && ev_tx_i)) begin
      irq_set[`LEPM_IRQ_EVT] = 1'b1;
    end
    if (tmr_expired || (prb_st != PRB_IDLE && prb_resp_valid_i && prb_resp_addr_i == prb_dest_o)) begin
      irq_set[`LEPM_IRQ_PRB] = 1'b1;
    end
    // Write-one-to-clear; a new event in the same cycle wins over the clear
    next_irq_stat = irq_stat;
    if (ap_wr && ap_addr == `LEPM_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~hwdata_i[2:0];
    end
    next_irq_stat = next_irq_stat | irq_set;
  end

  // Probe engine
  always_comb begin
    next_prb_st = prb_st;
    next_prb_ok = prb_ok;
    next_prb_refused = prb_refused;
    next_cmd_valid = prb_cmd_valid_o;
    next_bcn_req = prb_bcn_req_o;
    next_ie_id = prb_ie_id_o;
    next_spec = prb_spec_o;
    next_dest = prb_dest_o;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    prb_exp = hwdata_i[`LEPM_PRB_EXP_BIT];
    case (prb_st)
      PRB_IDLE: begin
        if (wr_go_prb) begin
          // Targets without probe support are refused, nothing is sent
          next_prb_refused = !prb_target_cap_i;
          if (prb_target_cap_i) begin
            next_ie_id = hwdata_i[7:0];
            next_spec = hwdata_i[31:`LEPM_PRB_SPEC_LSB];
            next_dest = prb_addr;
            next_prb_ok = 1'b0;
            tmr_start = 1'b1;
            next_prb_st = prb_exp ? PRB_SEND : PRB_WAIT_BCN;
            next_cmd_valid = prb_exp;
            next_bcn_req = !prb_exp;
          end
        end
      end
      PRB_SEND: begin
        if (prb_cmd_ready_i) begin
          next_cmd_valid = 1'b0;
          next_prb_st = PRB_WAIT_RESP;
        end
      end
      PRB_WAIT_BCN: begin
        // The element leaves the beacon after the first one sent
        if (bcn_tx_i) begin
          next_bcn_req = 1'b0;
          next_prb_st = PRB_WAIT_RESP;
        end
      end
      PRB_WAIT_RESP: ;
      default: next_prb_st = PRB_IDLE;
    endcase
    if (prb_st != PRB_IDLE) begin
      if (prb_resp_valid_i && prb_resp_addr_i == prb_dest_o) begin
        next_prb_ok = 1'b1;
        tmr_stop = 1'b1;
        next_prb_st = PRB_IDLE;
        next_cmd_valid = 1'b0;
        next_bcn_req = 1'b0;
      end else if (tmr_expired) begin
        next_prb_ok = 1'b0;
        next_prb_st = PRB_IDLE;
        next_cmd_valid = 1'b0;
        next_bcn_req = 1'b0;
      end
    end
  end

  // Timeout counter for the pending probe
  lepm_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(tmr_start),
    .stop_i(tmr_stop),
    .ms_i(prb_tmo),
    .expired_o(tmr_expired)
  );

  // All state registers except event capture and the timer; the bus, irq and probe outputs come straight from these flops
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ap_wr <= 1'b0;
      ap_addr <= 12'h000;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      mon_addr <= 48'h000000000000;
      prb_addr <= 48'h000000000000;
      mon_en_req <= 1'b0;
      mon_busy <= 1'b0;
      mon_ok <= 1'b0;
      prb_tmo <= `LEPM_TMO_RST;
      irq_stat <= `LEPM_IRQ_RST;
      irq_mask <= `LEPM_IRQ_RST;
      irq_o <= 1'b0;
      mon_vld <= '0;
      for (int i = 0; i < MON_N; i++) begin
        mon_tab[i] <= 48'h000000000000;
      end
      prb_st <= PRB_IDLE;
      prb_ok <= 1'b0;
      prb_refused <= 1'b0;
      prb_cmd_valid_o <= 1'b0;
      prb_cmd_imm_ack_o <= 1'b1;
      prb_bcn_req_o <= 1'b0;
      prb_ie_id_o <= 8'h00;
      prb_spec_o <= 16'h0000;
      prb_dest_o <= 48'h000000000000;
    end else begin
      ap_wr <= next_ap_wr;
      ap_addr <= next_ap_addr;
      hrdata_o <= next_hrdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      mon_addr <= next_mon_addr;
      prb_addr <= next_prb_addr;
      mon_en_req <= next_mon_en_req;
      mon_busy <= next_mon_busy;
      mon_ok <= next_mon_ok;
      prb_tmo <= next_prb_tmo;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq_o <= |(next_irq_stat & next_irq_mask);
      mon_vld <= next_mon_vld;
      mon_tab <= next_mon_tab;
      prb_st <= next_prb_st;
      prb_ok <= next_prb_ok;
      prb_refused <= next_prb_refused;
      prb_cmd_valid_o <= next_cmd_valid;
      prb_cmd_imm_ack_o <= 1'b1;
      prb_bcn_req_o <= next_bcn_req;
      prb_ie_id_o <= next_ie_id;
      prb_spec_o <= next_spec;
      prb_dest_o <= next_dest;
    end
  end

  // Event capture; transmitted beacons are never reported
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_valid_o <= 1'b0;
      evt_type_o <= EVT_RX_OK;
      evt_beacon_o <= 1'b0;
      evt_drp_o <= 1'b0;
      evt_payload_o <= 14'h0000;
      evt_rate_o <= RATE_53_3;
      evt_addr_o <= 48'h000000000000;
      evt_retry_o <= 4'h0;
      evt_rxerr_o <= RXE_NONE;
      evt_delivery_id_o <= 4'h0;
    end else begin
      evt_valid_o <= ev_valid_i && ev_hit && !(ev_beacon_i && ev_tx_i);
      if (ev_valid_i) begin
        if (!ev_tx_i) begin
          evt_type_o <= ev_ok_i ? EVT_RX_OK : EVT_RX_ERR;
        end else begin
          evt_type_o <= (!ev_ack_policy_i || ev_ok_i) ? EVT_TX_OK : EVT_TX_ERR;
        end
        evt_beacon_o <= ev_beacon_i;
        evt_drp_o <= ev_drp_i && !ev_beacon_i;
        // Short frames clamp to zero instead of wrapping
        evt_payload_o <= (ev_len_i > `LEPM_FCS_BYTES) ? ev_len_i - `LEPM_FCS_BYTES : 14'h0000;
        evt_rate_o <= ev_rate_i;
        evt_addr_o <= ev_addr_i;
        evt_retry_o <= ev_tx_i ? ev_attempts_i : 4'h0;
        evt_rxerr_o <= (!ev_tx_i && !ev_ok_i) ? ev_rxerr_i : RXE_NONE;
        evt_delivery_id_o <= (ev_drp_i && !ev_beacon_i) ? ev_delivery_id_i : 4'h0;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_mon_go;
    wr_go_mon && !mon_busy;
  endsequence
  sequence s_mon_cfm;
    mon_busy ##1 (!mon_busy && irq_stat[`LEPM_IRQ_MON]);
  endsequence
  property p_evt_mon;
    evt_valid_o |-> $past(ev_hit) && $past(ev_valid_i);
  endproperty
  a_evt_mon: assert property (p_evt_mon) else $error("event for unmonitored link");
  property p_empty_quiet;
    (mon_vld == '0) |=> !evt_valid_o;
  endproperty
  a_empty_quiet: assert property (p_empty_quiet) else $error("event with empty table");
  property p_bcn;
    evt_valid_o && evt_beacon_o |-> !evt_drp_o && (evt_type_o inside {EVT_RX_OK, EVT_RX_ERR});
  endproperty
  a_bcn: assert property (p_bcn) else $error("beacon event malformed");
  property p_txerr;
    evt_valid_o && evt_type_o == EVT_TX_ERR |-> $past(ev_ack_policy_i) && !$past(ev_ok_i);
  endproperty
  a_txerr: assert property (p_txerr) else $error("tx error without ack policy");
  property p_payload;
    evt_valid_o && $past(ev_len_i) > 14'h0004 |-> evt_payload_o == $past(ev_len_i) - 14'h0004;
  endproperty
  a_payload: assert property (p_payload) else $error("payload size wrong");
  property p_rxerr;
    evt_valid_o && evt_type_o != EVT_RX_ERR |-> evt_rxerr_o == RXE_NONE;
  endproperty
  a_rxerr: assert property (p_rxerr) else $error("error detail on non-error");
  property p_retry;
    evt_valid_o && $past(ev_tx_i) |-> evt_retry_o == $past(ev_attempts_i);
  endproperty
  a_retry: assert property (p_retry) else $error("retry count wrong");
  property p_mon_cfm;
    s_mon_go |=> s_mon_cfm;
  endproperty
  a_mon_cfm: assert property (p_mon_cfm) else $error("monitor confirm missing");
  property p_bcn_next;
    prb_st == PRB_WAIT_BCN && bcn_tx_i |=> !prb_bcn_req_o;
  endproperty
  a_bcn_next: assert property (p_bcn_next) else $error("probe not dropped after beacon");
  property p_timeout;
    tmr_expired && prb_st != PRB_IDLE && !prb_resp_valid_i |=> prb_st == PRB_IDLE && !prb_ok;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not reported");
endmodule : lepm_top

// file: verification/lepm_peer_model.sv
// Far-side model: MAC datapath and remote peer serving probe requests
module lepm_peer_model (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic answer_i,
  input wire logic [1:0] lag_i,
  input wire logic cmd_valid_i,
  input wire logic bcn_req_i,
  input wire logic [47:0] dest_i,
  output logic cmd_ready_o,
  output logic bcn_tx_o,
  output logic resp_valid_o,
  output logic [47:0] resp_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sent;
  logic [2:0] w;
  // Take the request after a lag, then answer a few cycles later only when told to
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sent <= 1'h0;
      w <= 3'h0;
      cmd_ready_o <= 1'h0;
      bcn_tx_o <= 1'h0;
      resp_valid_o <= 1'h0;
      resp_addr_o <= 48'h0;
    end else begin
      cmd_ready_o <= 1'h0;
      bcn_tx_o <= 1'h0;
      resp_valid_o <= 1'h0;
      resp_addr_o <= ~resp_addr_o; // Idle bus never repeats the last address
      w <= w + 3'h1;
      if (!sent && (cmd_valid_i || bcn_req_i) && w[1:0] == lag_i) begin
        cmd_ready_o <= cmd_valid_i;
        bcn_tx_o <= bcn_req_i;
        sent <= 1'h1;
        w <= 3'h0;
      end
      if (sent && w == 3'h4) begin
        resp_valid_o <= answer_i;
        resp_addr_o <= dest_i;
        sent <= 1'h0;
      end
    end
  end
endmodule : lepm_peer_model

// file: verification/lepm_top_tb_top.sv
// Self-checking bench for the link event and probe manager
`include "lepm_defines.svh"
module lepm_top_tb_top import lepm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic bcn; logic tx; logic ok; logic ack; logic drp; logic [13:0] len; lepm_rate_t rate;
    logic [3:0] att; lepm_rxerr_t rxe; logic [3:0] did; lepm_evt_t ty; logic [13:0] pay; logic [3:0] rty;} lepm_row_t;
  logic clock_i, resetn_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o, ev_valid_i, ev_beacon_i, ev_tx_i;
  logic ev_ok_i, ev_ack_policy_i, ev_drp_i, evt_valid_o, evt_beacon_o, evt_drp_o, prb_target_cap_i, prb_cmd_valid_o;
  logic prb_cmd_ready_i, prb_cmd_imm_ack_o, prb_bcn_req_o, bcn_tx_i, prb_resp_valid_i, irq_o, answer;
  logic [1:0] htrans_i, lag;
  logic [2:0] hsize_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
  logic [47:0] ev_addr_i, evt_addr_o, prb_dest_o, prb_resp_addr_i;
  logic [13:0] ev_len_i, evt_payload_o;
  logic [3:0] ev_attempts_i, ev_delivery_id_i, evt_retry_o, evt_delivery_id_o;
  logic [7:0] prb_ie_id_o;
  logic [15:0] prb_spec_o;
  lepm_rate_t ev_rate_i, evt_rate_o;
  lepm_rxerr_t ev_rxerr_i, evt_rxerr_o;
  lepm_evt_t evt_type_o;
  int errors, cmp_count;
  localparam logic [47:0] A = 48'h02aa00000010;
  logic [11:0] rst_regs [6] = '{`LEPM_MON_STAT, `LEPM_PRB_TIMEOUT, `LEPM_PRB_STAT, `LEPM_IRQ_STAT, `LEPM_IRQ_MASK, 12'h0fc};
  // Event rows: inputs, then expected class, payload and retry count
  lepm_row_t rows [8] = '{
    '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 14'h0040, RATE_53_3, 4'h3, RXE_PAYLOAD, 4'h5, EVT_RX_OK, 14'h003c, 4'h0},
    '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 14'h0004, RATE_80, 4'h0, RXE_PAYLOAD, 4'h0, EVT_RX_ERR, 14'h0000, 4'h0},
    '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 14'h0005, RATE_106_7, 4'h0, RXE_UNSUP_RATE, 4'h9, EVT_RX_ERR, 14'h0001, 4'h0},
    '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 14'h3fff, RATE_160, 4'h2, RXE_GENERAL, 4'h6, EVT_RX_OK, 14'h3ffb, 4'h0},
    '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 14'h0010, RATE_200, 4'h1, RXE_NONE, 4'h7, EVT_TX_OK, 14'h000c, 4'h1},
    '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 14'h0100, RATE_320, 4'h2, RXE_NONE, 4'h3, EVT_TX_OK, 14'h00fc, 4'h2},
    '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 14'h0020, RATE_400, 4'hf, RXE_NONE, 4'ha, EVT_TX_ERR, 14'h001c, 4'hf},
    '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 14'h0008, RATE_480, 4'h0, RXE_GENERAL, 4'hc, EVT_RX_ERR, 14'h0004, 4'h0}};
  // Single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;
  lepm_top #(.MS_CYCLES(4)) DUT (.clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .ev_valid_i, .ev_addr_i, .ev_beacon_i, .ev_tx_i, .ev_ok_i,
    .ev_ack_policy_i, .ev_drp_i, .ev_len_i, .ev_rate_i, .ev_attempts_i, .ev_rxerr_i, .ev_delivery_id_i, .evt_valid_o,
    .evt_type_o, .evt_beacon_o, .evt_drp_o, .evt_payload_o, .evt_rate_o, .evt_addr_o, .evt_retry_o, .evt_rxerr_o,
    .evt_delivery_id_o, .prb_target_cap_i, .prb_cmd_valid_o, .prb_cmd_ready_i, .prb_cmd_imm_ack_o, .prb_bcn_req_o,
    .bcn_tx_i, .prb_dest_o, .prb_ie_id_o, .prb_spec_o, .prb_resp_valid_i, .prb_resp_addr_i, .irq_o);
  lepm_peer_model peer (.clock_i, .resetn_i, .answer_i(answer), .lag_i(lag), .cmd_valid_i(prb_cmd_valid_o),
    .bcn_req_i(prb_bcn_req_o), .dest_i(prb_dest_o), .cmd_ready_o(prb_cmd_ready_i), .bcn_tx_o(bcn_tx_i),
    .resp_valid_o(prb_resp_valid_i), .resp_addr_o(prb_resp_addr_i));
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  task automatic tally_and_finish;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bounded wait for hready at a rising edge; a hang counts as a mismatch
  task automatic step;
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hready_i !== 1'h1 && n < 50);
    if (n >= 50) begin
      errors++;
      tally_and_finish();
    end
  endtask : step
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {20'h0, a};
    step();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    step();
    q = hrdata_o;
  endtask : ahb
  // Read a status word until its busy bit clears
  task automatic poll(input logic [11:0] a);
    int n;
    n = 0;
    do begin
      ahb(1'h0, a, 32'h0);
      n++;
    end while (q[0] !== 1'h0 && n < 2000);
    if (n >= 2000) begin
      errors++;
      tally_and_finish();
    end
  endtask : poll
  task automatic mon(input logic [47:0] a, input logic en, input logic ok);
    ahb(1'h1, `LEPM_MON_ADDR_LO, a[31:0]);
    ahb(1'h1, `LEPM_MON_ADDR_HI, {16'h0, a[47:32]});
    ahb(1'h1, `LEPM_MON_CMD, {30'h0, 1'h1, en});
    poll(`LEPM_MON_STAT);
    chk("mon_result", ok, q[1]);
  endtask : mon
  task automatic ev(input lepm_row_t r, input logic [47:0] a, input logic hit);
    logic [79:0] e;
    {ev_beacon_i, ev_tx_i, ev_ok_i, ev_ack_policy_i, ev_drp_i, ev_len_i} <= {r.bcn, r.tx, r.ok, r.ack, r.drp, r.len};
    ev_rate_i <= r.rate;
    ev_attempts_i <= r.att;
    ev_rxerr_i <= r.rxe;
    ev_delivery_id_i <= r.did;
    ev_addr_i <= a;
    ev_valid_i <= 1'h1;
    @(posedge clock_i);
    ev_valid_i <= 1'h0;
    #1;
    e = {hit, r.ty, r.bcn, r.drp & ~r.bcn, r.pay, r.rate, a, r.rty, (r.ty == EVT_RX_ERR) ? r.rxe : RXE_NONE,
      (r.drp & ~r.bcn) ? r.did : 4'h0};
    if (!hit) chk("evt_valid", 1'h0, evt_valid_o);
    else chk("event", e, {evt_valid_o, evt_type_o,
      evt_beacon_o, evt_drp_o, evt_payload_o, evt_rate_o, evt_addr_o, evt_retry_o, evt_rxerr_o, evt_delivery_id_o});
    @(posedge clock_i);
  endtask : ev
  task automatic prb(input logic ex, input logic [15:0] t, input logic cap, input logic ans, input logic [1:0] lg,
                     input logic [2:0] st);
    ahb(1'h1, `LEPM_PRB_ADDR_LO, 32'h0e0f1011);
    ahb(1'h1, `LEPM_PRB_ADDR_HI, 32'h0000a0b0);
    ahb(1'h1, `LEPM_PRB_TIMEOUT, {16'h0, t});
    prb_target_cap_i <= cap;
    answer <= ans;
    lag <= lg;
    ahb(1'h1, `LEPM_PRB_CTRL, {16'hc0de, 6'h0, 1'h1, ex, 8'hdd});
    #1;
    chk("prb_req", {cap & ex, cap & ~ex, 1'h1},
      {prb_cmd_valid_o, prb_bcn_req_o, prb_cmd_imm_ack_o});
    if (cap) chk("prb_id", {48'ha0b00e0f1011, 8'hdd, 16'hc0de},
      {prb_dest_o, prb_ie_id_o, prb_spec_o});
    @(posedge clock_i);
    poll(`LEPM_PRB_STAT);
    chk("prb_stat", st, q[2:0]);
  endtask : prb
  // Main sequence: reset, register checks, event rows, then monitor and probe corner cases
  initial begin
    clock_i = 1'h0;
    resetn_i = 1'h0;
    hsel_i = 1'h1;
    hsize_i = 3'h2;
    {htrans_i, hwrite_i, haddr_i, hwdata_i, prb_target_cap_i, answer, lag} = '0;
    {ev_valid_i, ev_addr_i, ev_beacon_i, ev_tx_i, ev_ok_i, ev_ack_policy_i, ev_drp_i} = '0;
    {ev_len_i, ev_attempts_i, ev_delivery_id_i} = '0;
    ev_rate_i = RATE_53_3;
    ev_rxerr_i = RXE_NONE;
    errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'h1;
    @(posedge clock_i);
    ahb(1'h1, 12'h0fc, 32'hffffffff);
    foreach (rst_regs[i]) begin
      ahb(1'h0, rst_regs[i], 32'h0);
      chk("reset_value", 33'h0, {hresp_o, q});
    end
    ev(rows[0], A, 1'h0);
    ahb(1'h1, `LEPM_IRQ_MASK, 32'h1);
    ahb(1'h0, `LEPM_IRQ_MASK, 32'h0);
    chk("irq_mask", 32'h1, q);
    mon(A, 1'h1, 1'h1);
    chk("irq_on", 1'h1, irq_o);
    ahb(1'h1, `LEPM_IRQ_STAT, 32'h1);
    ahb(1'h0, `LEPM_IRQ_STAT, 32'h0);
    chk("irq_clear", {32'h0, 1'h0}, {q, irq_o});
    foreach (rows[i]) ev(rows[i], A, 1'h1);
    ev({2'h3, rows[0][49:0]}, A, 1'h0);
    ahb(1'h0, `LEPM_IRQ_STAT, 32'h0);
    chk("irq_masked", {32'h2, 1'h0}, {q, irq_o});
    ev(rows[5], A + 48'h9, 1'h0);
    mon(A, 1'h0, 1'h1);
    ev(rows[4], A, 1'h0);
    // Table holds four links: the fifth enable fails, a repeated enable succeeds
    for (int i = 1; i < 6; i++) mon(A + 48'(i), 1'h1, i < 5);
    mon(A + 48'h1, 1'h1, 1'h1);
    chk("table", 4'hf, q[7:4]);
    prb(1'h1, 16'h0064, 1'h1, 1'h1, 2'h2, 3'h2);
    prb(1'h0, 16'h0064, 1'h1, 1'h1, 2'h0, 3'h2);
    prb(1'h1, 16'h0001, 1'h1, 1'h0, 2'h1, 3'h0);
    prb(1'h0, 16'h0000, 1'h1, 1'h0, 2'h3, 3'h0);
    prb(1'h1, 16'h0064, 1'h0, 1'h1, 2'h0, 3'h4);
    tally_and_finish();
  end
endmodule : lepm_top_tb_top
